/* File: verilog/dinit_pkg.sv */
// constants shared by the ddr2 initialization controller
// assumes one pclk domain at 125 MHz
package dinit_pkg;
  // ============================================================
  // clock
  localparam int CLK_PERIOD_PS = 8000;
  // ============================================================
  // timing, in own units and derived cycles
  localparam int T_STABLE_US = 200;
  localparam int T_STABLE_CYC =
    (T_STABLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_CKE_NOP_NS = 400;
  localparam int T_CKE_NOP_CYC =
    (T_CKE_NOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T_DLL_LOCK_CYC = 200;
  localparam int T_MRD_CYC = 2;
  localparam int T_RP_CYC = 4;
  localparam int T_RFC_CYC = 16;
  localparam int AUTO_REFRESH_COUNT = 2;
  // ============================================================
  // apb register offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] MODE_OFF = 12'h008;
  localparam logic [11:0] EXT1_OFF = 12'h00C;
  localparam logic [11:0] EXT2_OFF = 12'h010;
  localparam logic [11:0] EXT3_OFF = 12'h014;
  // ctrl fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SKIPCAL_BIT = 1;
  // stat fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_LOCKED_BIT = 2;
  // reset values
  localparam logic [13:0] MODE_RST = 14'h0442;
  localparam logic [13:0] EXT1_RST = 14'h0000;
  localparam logic [13:0] EXT2_RST = 14'h0000;
  localparam logic [13:0] EXT3_RST = 14'h0000;
  // ============================================================
  // field positions and ocd values in mode/extended words, precharge-all address bit
  localparam int MODE_DLLRST_BIT = 8;
  localparam int MODE_TEST_BIT = 7;
  localparam int EXT1_DLLDIS_BIT = 0;
  localparam int OCD_LSB = 7;
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;
  localparam int PALL_BIT = 10;
  // ============================================================
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  // bank selectors for mode writes
  localparam logic [2:0] BA_MODE = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;

  typedef enum logic [3:0] {
    DINIT_IDLE, DINIT_STABLE, DINIT_CKE, DINIT_PRE1, DINIT_EMR2,
    DINIT_EMR3, DINIT_EMR1, DINIT_MRDLL, DINIT_PRE2, DINIT_REF,
    DINIT_MRRUN, DINIT_OCDDEF, DINIT_OCDEXIT, DINIT_LOCK, DINIT_DONE
  } dinit_state_e;
endpackage

/* File: verilog/dinit_ctrl.sv */
// ddr2 power-up initialization sequencer with apb control registers
// assumes pclk 125 MHz, device command pins sampled by memory clock
// derived from pclk outside this block
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module dinit_ctrl #(
  parameter int STABLE_CYC = dinit_pkg::T_STABLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_cke,
  output logic mem_odt,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [2:0] mem_ba,
  output logic [15:0] mem_addr,
  output logic init_done
);
  // ============================================================
  // state
  typedef struct packed {
    // sequencer
    dinit_pkg::dinit_state_e st;
    logic [17:0] wait_cnt;
    logic [7:0] lock_cnt;
    logic [7:0] cal_cnt;
    logic [1:0] ref_cnt;
    // apb registers
    logic skip_cal;
    logic done;
    logic [13:0] mode_word;
    logic [13:0] ext1_word;
    logic [13:0] ext2_word;
    logic [13:0] ext3_word;
    // command pins and apb read data
    logic cke;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
    logic [31:0] rdata;
  } dinit_state_s;

  dinit_state_s s_reg;
  dinit_state_s s_next;

  localparam logic [17:0] STABLE_N = 18'(STABLE_CYC);
  localparam logic [17:0] CKE_N = 18'(dinit_pkg::T_CKE_NOP_CYC);
  localparam logic [17:0] MRD_N = 18'(dinit_pkg::T_MRD_CYC);
  localparam logic [17:0] RP_N = 18'(dinit_pkg::T_RP_CYC);
  localparam logic [17:0] RFC_N = 18'(dinit_pkg::T_RFC_CYC);
  localparam logic [7:0] LOCK_N = 8'(dinit_pkg::T_DLL_LOCK_CYC);
  localparam logic [1:0] REF_N = 2'(dinit_pkg::AUTO_REFRESH_COUNT);

  logic wr_acc;
  logic rd_acc;
  logic gap_done;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign gap_done = (s_reg.wait_cnt == 18'h00000);

  // ============================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.cmd = dinit_pkg::CMD_NOP;
    s_next.ba = 3'h0;
    s_next.addr = 16'h0000;
    // one down-counter times every command gap but the wait on cal_cnt before the ocd write
    if (s_reg.wait_cnt != 18'h00000) begin
      s_next.wait_cnt = s_reg.wait_cnt - 18'h00001;
    end
    // lock timer keeps running through later steps
    if (s_reg.lock_cnt != 8'h00) begin
      s_next.lock_cnt = s_reg.lock_cnt - 8'h01;
    end
    // calibration may not start before this expires
    if (s_reg.cal_cnt != 8'h00) begin
      s_next.cal_cnt = s_reg.cal_cnt - 8'h01;
    end

    // register writes
    if (wr_acc) begin
      unique case (paddr)
        // start refused while a sequence runs
        dinit_pkg::CTRL_OFF: begin
          if (pwdata[dinit_pkg::CTRL_START_BIT] &&
              (s_reg.st == dinit_pkg::DINIT_IDLE ||
               s_reg.st == dinit_pkg::DINIT_DONE)) begin
            // rerun allowed only from idle or once the sequence is done
            s_next.skip_cal = pwdata[dinit_pkg::CTRL_SKIPCAL_BIT];
            s_next.done = 1'b0;
            s_next.st = dinit_pkg::DINIT_STABLE;
            s_next.wait_cnt = STABLE_N;
          end
        end
        dinit_pkg::MODE_OFF: s_next.mode_word = pwdata[13:0];
        dinit_pkg::EXT1_OFF: s_next.ext1_word = pwdata[13:0];
        dinit_pkg::EXT2_OFF: s_next.ext2_word = pwdata[13:0];
        dinit_pkg::EXT3_OFF: s_next.ext3_word = pwdata[13:0];
        default: begin
        end
      endcase
    end

    // read data captured in setup, held until next read
    if (rd_acc) begin
      unique case (paddr)
        dinit_pkg::STAT_OFF: begin
          s_next.rdata = 32'h00000000;
          s_next.rdata[dinit_pkg::STAT_BUSY_BIT] =
            (s_reg.st != dinit_pkg::DINIT_IDLE) &&
            (s_reg.st != dinit_pkg::DINIT_DONE);
          s_next.rdata[dinit_pkg::STAT_DONE_BIT] = s_reg.done;
          s_next.rdata[dinit_pkg::STAT_LOCKED_BIT] =
            (s_reg.lock_cnt == 8'h00);
        end
        dinit_pkg::CTRL_OFF: s_next.rdata = {30'h0, s_reg.skip_cal, 1'b0};
        dinit_pkg::MODE_OFF: s_next.rdata = {18'h0, s_reg.mode_word};
        dinit_pkg::EXT1_OFF: s_next.rdata = {18'h0, s_reg.ext1_word};
        dinit_pkg::EXT2_OFF: s_next.rdata = {18'h0, s_reg.ext2_word};
        dinit_pkg::EXT3_OFF: s_next.rdata = {18'h0, s_reg.ext3_word};
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    // ==========================================================
    // sequencer; each command is one cycle, nop fills every gap
    unique case (s_reg.st)
      dinit_pkg::DINIT_IDLE: begin
      end

      // power-up waits
      dinit_pkg::DINIT_STABLE: begin
        if (gap_done) begin
          s_next.cke = 1'b1;
          s_next.wait_cnt = CKE_N;
          s_next.st = dinit_pkg::DINIT_CKE;
        end
      end

      dinit_pkg::DINIT_CKE: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_PRE;
          s_next.addr[dinit_pkg::PALL_BIT] = 1'b1;
          s_next.wait_cnt = RP_N;
          s_next.st = dinit_pkg::DINIT_PRE1;
        end
      end

      // register writes after precharge
      dinit_pkg::DINIT_PRE1: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_MRS;
          s_next.ba = dinit_pkg::BA_EMR2;
          s_next.addr = {2'b00, s_reg.ext2_word};
          s_next.wait_cnt = MRD_N;
          s_next.st = dinit_pkg::DINIT_EMR2;
        end
      end

      dinit_pkg::DINIT_EMR2: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_MRS;
          s_next.ba = dinit_pkg::BA_EMR3;
          s_next.addr = {2'b00, s_reg.ext3_word};
          s_next.wait_cnt = MRD_N;
          s_next.st = dinit_pkg::DINIT_EMR3;
        end
      end

      dinit_pkg::DINIT_EMR3: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_MRS;
          s_next.ba = dinit_pkg::BA_EMR1;
          s_next.addr = {2'b00, s_reg.ext1_word};
          s_next.addr[dinit_pkg::EXT1_DLLDIS_BIT] = 1'b0;
          s_next.addr[dinit_pkg::OCD_LSB +: 3] = dinit_pkg::OCD_EXIT;
          s_next.addr[15:13] = 3'h0;
          s_next.cal_cnt = LOCK_N;
          s_next.wait_cnt = MRD_N;
          s_next.st = dinit_pkg::DINIT_EMR1;
        end
      end

      dinit_pkg::DINIT_EMR1: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_MRS;
          s_next.ba = dinit_pkg::BA_MODE;
          s_next.addr = {2'b00, s_reg.mode_word};
          s_next.addr[dinit_pkg::MODE_DLLRST_BIT] = 1'b1;
          s_next.addr[dinit_pkg::MODE_TEST_BIT] = 1'b0;
          s_next.addr[15:13] = 3'h0;
          s_next.lock_cnt = LOCK_N;
          s_next.wait_cnt = MRD_N;
          s_next.st = dinit_pkg::DINIT_MRDLL;
        end
      end

      // refresh, then operating mode
      dinit_pkg::DINIT_MRDLL: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_PRE;
          s_next.addr[dinit_pkg::PALL_BIT] = 1'b1;
          s_next.wait_cnt = RP_N;
          s_next.ref_cnt = 2'h0;
          s_next.st = dinit_pkg::DINIT_PRE2;
        end
      end

      dinit_pkg::DINIT_PRE2, dinit_pkg::DINIT_REF: begin
        if (gap_done) begin
          if (s_reg.ref_cnt != REF_N) begin
            s_next.cmd = dinit_pkg::CMD_REF;
            s_next.ref_cnt = s_reg.ref_cnt + 2'h1;
            s_next.wait_cnt = RFC_N;
            s_next.st = dinit_pkg::DINIT_REF;
          end else begin
            s_next.cmd = dinit_pkg::CMD_MRS;
            s_next.ba = dinit_pkg::BA_MODE;
            s_next.addr = {2'b00, s_reg.mode_word};
            s_next.addr[dinit_pkg::MODE_DLLRST_BIT] = 1'b0;
            s_next.addr[dinit_pkg::MODE_TEST_BIT] = 1'b0;
            s_next.wait_cnt = MRD_N;
            s_next.st = dinit_pkg::DINIT_MRRUN;
          end
        end
      end

      // calibration default (only with skip_cal set) and exit
      dinit_pkg::DINIT_MRRUN: begin
        if (gap_done && s_reg.cal_cnt == 8'h00) begin
          s_next.cmd = dinit_pkg::CMD_MRS;
          s_next.ba = dinit_pkg::BA_EMR1;
          s_next.addr = {2'b00, s_reg.ext1_word};
          s_next.addr[dinit_pkg::EXT1_DLLDIS_BIT] = 1'b0;
          s_next.addr[dinit_pkg::OCD_LSB +: 3] = s_reg.skip_cal ?
            dinit_pkg::OCD_DEFAULT : dinit_pkg::OCD_EXIT;
          s_next.wait_cnt = MRD_N;
          s_next.st = dinit_pkg::DINIT_OCDDEF;
        end
      end

      dinit_pkg::DINIT_OCDDEF: begin
        if (gap_done) begin
          s_next.cmd = dinit_pkg::CMD_MRS;
          s_next.ba = dinit_pkg::BA_EMR1;
          s_next.addr = {2'b00, s_reg.ext1_word};
          s_next.addr[dinit_pkg::EXT1_DLLDIS_BIT] = 1'b0;
          s_next.addr[dinit_pkg::OCD_LSB +: 3] = dinit_pkg::OCD_EXIT;
          s_next.wait_cnt = MRD_N;
          s_next.st = dinit_pkg::DINIT_OCDEXIT;
        end
      end

      dinit_pkg::DINIT_OCDEXIT: begin
        if (gap_done) begin
          s_next.st = dinit_pkg::DINIT_LOCK;
        end
      end

      // reads legal only once lock time is over
      dinit_pkg::DINIT_LOCK: begin
        if (s_reg.lock_cnt == 8'h00) begin
          s_next.done = 1'b1;
          s_next.st = dinit_pkg::DINIT_DONE;
        end
      end

      dinit_pkg::DINIT_DONE: begin
      end

      default: s_next.st = dinit_pkg::DINIT_IDLE;
    endcase
  end

  // ============================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= dinit_pkg::DINIT_IDLE;
      s_reg.cmd <= dinit_pkg::CMD_NOP;
      s_reg.cke <= 1'b0;
      s_reg.mode_word <= dinit_pkg::MODE_RST;
      s_reg.ext1_word <= dinit_pkg::EXT1_RST;
      s_reg.ext2_word <= dinit_pkg::EXT2_RST;
      s_reg.ext3_word <= dinit_pkg::EXT3_RST;
    end else if (clk_en) begin
      // clk_en low freezes every field
      s_reg <= s_next;
    end
  end

  // ============================================================
  // outputs
  assign prdata = s_reg.rdata;
  assign pslverr = 1'b0;
  assign mem_cke = s_reg.cke;
  assign mem_odt = 1'b0;
  assign mem_cs_n = s_reg.cmd[3];
  assign mem_ras_n = s_reg.cmd[2];
  assign mem_cas_n = s_reg.cmd[1];
  assign mem_we_n = s_reg.cmd[0];
  assign mem_ba = s_reg.ba;
  assign mem_addr = s_reg.addr;
  assign init_done = s_reg.done;
endmodule

/* File: sim/dinit_checker.sv */
// pin assertions for the init controller
// assumes binding onto dinit_ctrl, one pclk domain
`timescale 1ns/1ps
module dinit_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_cke,
  input wire logic mem_odt,
  input wire logic mem_cs_n,
  input wire logic mem_ras_n,
  input wire logic mem_cas_n,
  input wire logic mem_we_n,
  input wire logic [2:0] mem_ba,
  input wire logic [15:0] mem_addr,
  input wire logic init_done
);
  logic [3:0] cmd;
  logic idle;
  logic mrs;
  logic [7:0] cke_cnt;
  assign cmd = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n};
  assign idle = mem_cs_n || cmd == dinit_pkg::CMD_NOP;
  assign mrs = cmd == dinit_pkg::CMD_MRS;
  // cycles with cke high, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke_cnt <= 8'h00;
    end else if (!mem_cke) begin
      cke_cnt <= 8'h00;
    end else if (cke_cnt != 8'hFF) begin
      cke_cnt <= cke_cnt + 8'h01;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  odt_low_a: assert property (
    !mem_odt) else $error("odt high");
  cke_wait_a: assert property (
    !idle |-> cke_cnt >= 8'h32) else $error("command too early");
  pre_all_a: assert property (
    cmd == dinit_pkg::CMD_PRE |-> mem_addr[10]) else $error("not all");
  high_zero_a: assert property (
    mrs |-> mem_addr[15:13] == 3'h0 && !mem_ba[2]) else $error("high bits");
  test_low_a: assert property (
    mrs && mem_ba == dinit_pkg::BA_MODE |-> !mem_addr[7])
    else $error("test");
  dll_on_a: assert property (
    mrs && mem_ba == dinit_pkg::BA_EMR1 |-> !mem_addr[0]) else $error("dll");
  one_cmd_a: assert property (
    !idle |=> idle) else $error("command held");
  mrs_gap_a: assert property (
    mrs |=> idle [*2]) else $error("mode write gap");
  done_quiet_a: assert property (
    init_done |-> idle && mem_cke) else $error("busy after done");
  ref_c: cover property (cmd == dinit_pkg::CMD_REF);
  cal_c: cover property (mrs && mem_addr[9:7] == 3'h7);
  done_c: cover property ($rose(init_done));
endmodule

bind dinit_ctrl dinit_checker chk (.pclk(pclk), .presetn(presetn),
  .mem_cke(mem_cke), .mem_odt(mem_odt), .mem_cs_n(mem_cs_n),
  .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n),
  .mem_ba(mem_ba), .mem_addr(mem_addr), .init_done(init_done));

/* File: sim/dinit_dev_model.sv */
// behavioural ddr2 device: mode registers and command log
// assumes pins sampled on the rising controller clock edge
`timescale 1ns/1ps
module dinit_dev_model (
  input wire logic clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr
);
  logic [13:0] regs [4];
  logic [13:0] row [8];
  logic [13:0] col;
  logic auto_pre;
  logic cke_q = 1'b0;
  logic [3:0] cmd;
  logic [22:0] log_q [$];
  int cyc_q [$];
  int cyc = 0;
  int rise_cyc = 0;
  logic [2:0] burst;
  logic [2:0] cas_lat;
  logic dm_on;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // ==========================================
  // field decode
  assign burst = regs[0][2:0];
  assign cas_lat = regs[0][6:4];
  assign dm_on = !regs[1][11];
  // ==========================================
  // sampling; mode writes never touch stored data
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cke && !cke_q) begin
      rise_cyc = cyc;
    end
    cke_q = cke;
    if (cke && !cs_n && cmd != dinit_pkg::CMD_NOP) begin
      log_q.push_back({cmd, ba, addr});
      cyc_q.push_back(cyc);
    end
    if (cke && cmd == dinit_pkg::CMD_MRS) begin
      regs[ba[1:0]] = addr[13:0];
    end
    if (cke && cmd == 4'h3) begin
      row[ba] = addr[13:0];
    end
    if (cke && cmd[3:1] == 3'h2) begin
      col = addr[13:0];
      auto_pre = addr[10];
    end
  end
endmodule

/* File: sim/tb_ddr2_init_mode_register.sv */
// self-checking bench of the ddr2 init controller
// assumes checker and device model compiled before it
`timescale 1ns/1ps
module tb_ddr2_init_mode_register;
  localparam logic [3:0] MRS = dinit_pkg::CMD_MRS;
  localparam logic [6:0] PRE = {dinit_pkg::CMD_PRE, 3'h0};
  localparam logic [6:0] REF = {dinit_pkg::CMD_REF, 3'h0};
  logic pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, mem_cke, mem_odt, init_done;
  logic mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
  logic [2:0] mem_ba;
  logic [15:0] mem_addr;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  dinit_ctrl #(.STABLE_CYC(20)) dut (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_cke(mem_cke), .mem_odt(mem_odt),
    .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr),
    .init_done(init_done));
  dinit_dev_model m (.clk(pclk), .cke(mem_cke), .cs_n(mem_cs_n),
    .ras_n(mem_ras_n), .cas_n(mem_cas_n), .we_n(mem_we_n), .ba(mem_ba),
    .addr(mem_addr));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    chk({31'h0, mem_cke}, 32'h0);
    apb(1'b0, dinit_pkg::MODE_OFF, 32'h0);
    chk(rd, {18'h0, dinit_pkg::MODE_RST});
    for (int i = 1; i < 6; i++) begin
      if (i != 2) begin
        apb(1'b0, 12'(4 * i), 32'h0);
        chk(rd, (i == 1) ? 32'h4 : 32'h0);
      end
    end
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, dinit_pkg::EXT1_OFF, 32'hFFFF_0428);
    apb(1'b0, dinit_pkg::EXT1_OFF, 32'h0);
    chk(rd, 32'h0000_0428);
    apb(1'b1, dinit_pkg::EXT2_OFF, 32'h0000_0080);
  endtask
  task automatic t_freeze;
    clk_en <= 1'b0;
    apb(1'b1, dinit_pkg::MODE_OFF, 32'h0000_1234);
    clk_en <= 1'b1;
    apb(1'b0, dinit_pkg::MODE_OFF, 32'h0);
    chk(rd, {18'h0, dinit_pkg::MODE_RST});
  endtask
  task automatic t_init(input logic skip, input logic [13:0] mode);
    logic [22:0] ex [$];
    logic [22:0] g;
    int n, k;
    apb(1'b1, dinit_pkg::MODE_OFF, {18'h0, mode});
    m.log_q.delete();
    m.cyc_q.delete();
    apb(1'b1, dinit_pkg::CTRL_OFF, {30'h0, skip, 1'b1});
    apb(1'b0, dinit_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'b0, dinit_pkg::CTRL_OFF, 32'h0);
    chk(rd, {30'h0, skip, 1'b0});
    if (!skip) begin
      chk({31'h0, mem_cke}, 32'h0);
    end
    // start while busy is refused
    apb(1'b1, dinit_pkg::CTRL_OFF, {30'h0, skip, 1'b1});
    k = 0;
    while (init_done !== 1'b1 && k < 3000) begin
      @(negedge pclk);
      k++;
    end
    chk({31'h0, init_done}, 32'h1);
    n = m.cyc;
    ex = '{{PRE, 16'h0400}, {MRS, dinit_pkg::BA_EMR2, 16'h0080},
      {MRS, dinit_pkg::BA_EMR3, 16'h0000},
      {MRS, dinit_pkg::BA_EMR1, 16'h0428},
      {MRS, dinit_pkg::BA_MODE, 2'h0, mode | 14'h0100},
      {PRE, 16'h0400}, {REF, 16'h0}, {REF, 16'h0},
      {MRS, dinit_pkg::BA_MODE, 2'h0, mode}};
    if (skip) begin
      ex.push_back({MRS, dinit_pkg::BA_EMR1, 16'h07A8});
    end
    ex.push_back({MRS, dinit_pkg::BA_EMR1, 16'h0428});
    k = m.log_q.size();
    chk(32'(k == 11 || (!skip && k == 10)), 32'h1);
    for (int i = 0; i < ex.size(); i++) begin
      g = m.log_q[(i < 9) ? i : k - ex.size() + i];
      if (ex[i][22:19] != MRS) begin
        g[18:0] = g[18:0] & ex[i][18:0];
      end
      chk({9'h0, g}, {9'h0, ex[i]});
    end
    chk(32'(m.cyc_q[0] - m.rise_cyc >= 50), 32'h1);
    chk(32'(m.cyc_q[9] - m.cyc_q[3] >= 200), 32'h1);
    chk(32'(n + 1 - m.cyc_q[4] >= 200), 32'h1);
    chk({18'h0, m.regs[0]}, {18'h0, mode});
    chk({29'h0, m.burst}, {29'h0, mode[2:0]});
    chk({29'h0, m.cas_lat}, {29'h0, mode[6:4]});
    chk({31'h0, m.dm_on}, 32'h1);
    apb(1'b0, dinit_pkg::STAT_OFF, 32'h0);
    chk(rd & 32'h7, 32'h6);
  endtask
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_freeze();
    t_init(1'b0, 14'h0A63);
    t_init(1'b1, 14'h0652);
    give_verdict();
  end
endmodule
